// ==== inc/hpp_defines.svh ====
/*
 * constants for the host parallel port: phase encoding, reset values, widths.
 * assumes inclusion by the package and design file only; definitions only.
 */
`ifndef HPP_DEFINES_SVH
`define HPP_DEFINES_SVH

`define HPP_DATA_W 8
`define HPP_PHASE_W 2
`define HPP_PHASE_ONE 2'h0
`define HPP_PHASE_TWO 2'h1
`define HPP_PHASE_FOUR 2'h3
`define HPP_PHASE_STEP 2'h1
`define HPP_BYTE_RST 8'h00
`define HPP_SYNC_IDLE 3'h7

`endif

// ==== inc/hpp_pkg.sv ====
/*
 * types for the host parallel port.
 * assumes hpp_defines.svh is on the include path.
 */
`include "hpp_defines.svh"
package hpp_pkg;
   typedef logic [`HPP_DATA_W-1:0] hpp_byte_t;
   // completion tracker: wait for phase two, then for phase four
   typedef enum logic [1:0] {
      HPP_IDLE = 2'b00,
      HPP_WAIT_TWO = 2'b01,
      HPP_WAIT_FOUR = 2'b10
   } hpp_done_t;
endpackage

// ==== src/hpp_slave_port.sv ====
/*
 * byte-wide slave port driven by an external processor through active-low
 * select, read and write strobes, with input and output latches, full and
 * overflow flags and a completion interrupt flag.
 * assumes strobes arrive asynchronously and firmware controls appear as
 * single-cycle pulses in the i_ref_clk domain; pin direction and analog
 * configuration are handled by firmware elsewhere.
 */
// How it works
// - slave behaviour only while slave_port_enable is high
// - enable turns three pins into read, write and select strobes
// - separate input and output latches; firmware writes output, reads input
// - direction register ignored; external strobes alone steer the data pins
// - write begins with select and write strobe both low
// - write release sets input full and interrupt flag at phase four after two
// - input full cleared by firmware reading the input latch or by leaving slave mode
// - write while unread byte pending sets overflow
// - select and read low clears output full and drives output latch
// - read release sets interrupt flag at phase four after phase two
// - output full stays low until firmware writes the output latch
// - outside mode full flags held clear; overflow kept until firmware clears
// - interrupt flag sticky until cleared; request gated by interrupt enable
// - instruction cycle is four clock periods, phases one to four
`include "hpp_defines.svh"
module hpp_slave_port (
   input wire logic i_ref_clk, // 25 MHz clock
   input wire logic i_reset_n, // async reset, active low
   input wire logic i_slave_port_enable, // slave mode enable
   input wire logic i_read_strobe_n_pin, // external read strobe
   input wire logic i_write_strobe_n_pin, // external write strobe
   input wire logic i_chip_select_n_pin, // external select
   input wire hpp_pkg::hpp_byte_t i_slave_data_port, // data pins in
   output hpp_pkg::hpp_byte_t o_slave_data_port, // data pins out
   output logic o_slave_data_port_oe, // data pins driven
   input wire logic i_fw_write, // firmware writes output latch
   input wire hpp_pkg::hpp_byte_t i_fw_wdata, // firmware write data
   input wire logic i_fw_read, // firmware reads input latch
   output hpp_pkg::hpp_byte_t o_fw_rdata, // input latch contents
   input wire logic i_fw_clear_overflow, // firmware clears overflow
   input wire logic i_fw_clear_int_flag, // firmware clears int flag
   input wire logic i_slave_port_int_enable, // interrupt enable
   output logic o_input_buffer_full, // input full flag
   output logic o_output_buffer_full, // output full flag
   output logic o_input_overflow, // overflow flag
   output logic o_slave_port_int_flag, // sticky completion flag
   output logic o_int_request, // gated interrupt request
   output logic [1:0] o_phase // current instruction phase
);
   import hpp_pkg::*;

   logic [2:0] sync1_q;
   logic [2:0] sync2_q;
   hpp_byte_t data1_q;
   hpp_byte_t data2_q;
   logic [`HPP_PHASE_W-1:0] phase_q;
   hpp_byte_t in_latch_q;
   hpp_byte_t out_latch_q;
   logic ibf_q;
   logic obf_q;
   logic input_overflow_q;
   logic int_flag_q;
   logic wr_act_q;
   logic rd_act_q;
   hpp_done_t wdone_q;
   hpp_done_t rdone_q;
   logic cs_low;
   logic wr_low;
   logic rd_low;
   logic wr_now;
   logic rd_now;
   logic wr_release;
   logic rd_release;
   logic wdone_fire;
   logic rdone_fire;
   logic at_two;
   logic at_four;

   // two-stage synchroniser; first stage feeds only the second. the data pins
   // ride the same two stages, so the byte kept is the one that stood while the
   // strobe was seen low, even if the host drops its data just after release
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         sync1_q <= `HPP_SYNC_IDLE;
         sync2_q <= `HPP_SYNC_IDLE;
         data1_q <= `HPP_BYTE_RST;
         data2_q <= `HPP_BYTE_RST;
      end else begin
         sync1_q <= {i_chip_select_n_pin, i_write_strobe_n_pin, i_read_strobe_n_pin};
         sync2_q <= sync1_q;
         data1_q <= i_slave_data_port;
         data2_q <= data1_q;
      end
   end

   // strobes are only meaningful while the port is in slave mode
   assign cs_low = i_slave_port_enable & ~sync2_q[2];
   assign wr_low = ~sync2_q[1];
   assign rd_low = ~sync2_q[0];
   assign wr_now = cs_low & wr_low;
   assign rd_now = cs_low & rd_low;
   assign wr_release = wr_act_q & ~wr_now;
   assign rd_release = rd_act_q & ~rd_now;

   // four-phase instruction cycle counter
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         phase_q <= `HPP_PHASE_ONE;
      end else begin
         phase_q <= phase_q + `HPP_PHASE_STEP;
      end
   end
   assign at_two = (phase_q == `HPP_PHASE_TWO);
   assign at_four = (phase_q == `HPP_PHASE_FOUR);
   assign o_phase = phase_q;

   // activity tracking gives one release per access, never repeated
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         wr_act_q <= 1'b0;
         rd_act_q <= 1'b0;
      end else begin
         wr_act_q <= wr_now;
         rd_act_q <= rd_now;
      end
   end

   // input latch follows the delayed pins during the write, keeping the last byte
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         in_latch_q <= `HPP_BYTE_RST;
      end else if (wr_now) begin
         in_latch_q <= data2_q;
      end
   end

   // write completion waits for phase two, then fires on phase four
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         wdone_q <= HPP_IDLE;
      end else begin
         case (wdone_q)
            HPP_IDLE: begin
               if (wr_release) begin
                  wdone_q <= at_two ? HPP_WAIT_FOUR : HPP_WAIT_TWO;
               end
            end
            HPP_WAIT_TWO: begin
               if (at_two) begin
                  wdone_q <= HPP_WAIT_FOUR;
               end
            end
            HPP_WAIT_FOUR: begin
               if (at_four) begin
                  wdone_q <= HPP_IDLE;
               end
            end
            default: begin
               wdone_q <= HPP_IDLE;
            end
         endcase
      end
   end
   assign wdone_fire = (wdone_q == HPP_WAIT_FOUR) & at_four;

   // read completion uses the same phase reference
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rdone_q <= HPP_IDLE;
      end else begin
         case (rdone_q)
            HPP_IDLE: begin
               if (rd_release) begin
                  rdone_q <= at_two ? HPP_WAIT_FOUR : HPP_WAIT_TWO;
               end
            end
            HPP_WAIT_TWO: begin
               if (at_two) begin
                  rdone_q <= HPP_WAIT_FOUR;
               end
            end
            HPP_WAIT_FOUR: begin
               if (at_four) begin
                  rdone_q <= HPP_IDLE;
               end
            end
            default: begin
               rdone_q <= HPP_IDLE;
            end
         endcase
      end
   end
   assign rdone_fire = (rdone_q == HPP_WAIT_FOUR) & at_four;

   // input full: set by completion, cleared by firmware read or by leaving slave mode; set wins over read
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ibf_q <= 1'b0;
      end else if (!i_slave_port_enable) begin
         ibf_q <= 1'b0;
      end else if (wdone_fire) begin
         ibf_q <= 1'b1;
      end else if (i_fw_read) begin
         ibf_q <= 1'b0;
      end
   end

   // overflow: a new write starting while the previous byte is unread
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         input_overflow_q <= 1'b0;
      end else if (wr_now & ~wr_act_q & ibf_q & ~i_fw_read) begin
         input_overflow_q <= 1'b1;
      end else if (i_fw_clear_overflow) begin
         input_overflow_q <= 1'b0;
      end
   end

   // output latch and its full flag; an external read wins over a firmware write
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         out_latch_q <= `HPP_BYTE_RST;
      end else if (i_fw_write) begin
         out_latch_q <= i_fw_wdata;
      end
   end
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         obf_q <= 1'b0;
      end else if (!i_slave_port_enable) begin
         obf_q <= 1'b0;
      end else if (rd_now & ~rd_act_q) begin
         obf_q <= 1'b0;
      end else if (i_fw_write) begin
         obf_q <= 1'b1;
      end
   end

   // sticky interrupt flag; a completion wins over the firmware clear
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         int_flag_q <= 1'b0;
      end else if (wdone_fire | rdone_fire) begin
         int_flag_q <= 1'b1;
      end else if (i_fw_clear_int_flag) begin
         int_flag_q <= 1'b0;
      end
   end

   // data pins driven only while the host reads; direction register plays no part
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_slave_data_port <= `HPP_BYTE_RST;
      end else begin
         o_slave_data_port <= out_latch_q;
      end
   end
   assign o_slave_data_port_oe = rd_now;
   assign o_fw_rdata = in_latch_q;
   assign o_input_buffer_full = ibf_q;
   assign o_output_buffer_full = obf_q;
   assign o_input_overflow = input_overflow_q;
   assign o_slave_port_int_flag = int_flag_q;
   assign o_int_request = int_flag_q & i_slave_port_int_enable;

   sequence s_write_release;
      wr_act_q && !wr_now && i_slave_port_enable;
   endsequence
   sequence s_read_release;
      rd_act_q && !rd_now;
   endsequence

   a_write_sets_full: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      s_write_release |-> ##[1:6] ((ibf_q && int_flag_q) || !i_slave_port_enable))
      else $error("write release did not set full and int flag");
   a_read_sets_flag: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      s_read_release |-> ##[1:7] int_flag_q)
      else $error("read release did not set int flag");
   a_fire_on_four: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      $rose(int_flag_q) |-> $past(phase_q) == `HPP_PHASE_FOUR)
      else $error("int flag rose off phase four");
   a_ibf_clear_only_read: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      $fell(ibf_q) |-> $past(i_fw_read) || !$past(i_slave_port_enable))
      else $error("input full cleared without read");
   a_overflow_on_second: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      wr_now && !wr_act_q && ibf_q && !i_fw_read |=> input_overflow_q)
      else $error("overflow not flagged");
   a_obf_read_clear: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      rd_now && !rd_act_q |=> !obf_q)
      else $error("output full not cleared on read");
   a_obf_held_off: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      !i_slave_port_enable |=> !obf_q && !ibf_q)
      else $error("full flags not held clear");
   a_obf_fw_set: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      i_fw_write && i_slave_port_enable && !(rd_now && !rd_act_q) |=> obf_q)
      else $error("firmware write did not set output full");
   a_int_gated: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      o_int_request |-> i_slave_port_int_enable && int_flag_q)
      else $error("interrupt request not gated");
   a_int_sticky: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      int_flag_q && !i_fw_clear_int_flag |=> int_flag_q)
      else $error("int flag dropped without a clear");
   a_drive_in_read: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      o_slave_data_port_oe |-> i_slave_port_enable && $past(i_read_strobe_n_pin, 2) == 1'b0)
      else $error("pins driven outside a read");
endmodule

// ==== tb/hpp_host_model.sv ====
/*
 * model of the external processor that drives the slave port strobes.
 * assumes the testbench calls its tasks and shares the device clock.
 */
module hpp_host_model (
   input wire logic i_clk, // device clock, used only to pace cycles
   input wire hpp_pkg::hpp_byte_t i_data, // data pins from the device
   output logic o_cs_n, // chip select, active low
   output logic o_rd_n, // read strobe, active low
   output logic o_wr_n, // write strobe, active low
   output hpp_pkg::hpp_byte_t o_data // data pins toward the device
);
   timeunit 1ns;
   timeprecision 1ps;
   import hpp_pkg::*;
   initial begin
      o_cs_n = 1'b1;
      o_rd_n = 1'b1;
      o_wr_n = 1'b1;
      o_data = 8'h00;
   end
   // select and write held low together for the whole cycle
   task automatic write_byte(input hpp_byte_t d, input int hold);
      @(posedge i_clk);
      #1;
      o_data = d;
      o_cs_n = 1'b0;
      o_wr_n = 1'b0;
      repeat (hold) @(posedge i_clk);
      #1;
      o_cs_n = 1'b1;
      o_wr_n = 1'b1;
      o_data = ~d; // released bus must not look like the old byte
   endtask
   // read held until the last edge, data taken at that edge
   task automatic read_byte(output hpp_byte_t d, input int hold);
      @(posedge i_clk);
      #1;
      o_cs_n = 1'b0;
      o_rd_n = 1'b0;
      repeat (hold) @(posedge i_clk);
      d = i_data;
      #1;
      o_cs_n = 1'b1;
      o_rd_n = 1'b1;
   endtask
endmodule

// ==== tb/tb.sv ====
/*
 * self-checking bench for the host parallel port.
 * assumes hpp_host_model plays the external processor; firmware is pulses.
 */
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin err_total++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import hpp_pkg::*;
   logic i_ref_clk = 1'b0, i_reset_n = 1'b0, i_slave_port_enable = 1'b0;
   logic cs_n, rd_n, wr_n, oe, fw_write = 1'b0, fw_read = 1'b0;
   logic clr_ov = 1'b0, clr_int = 1'b0, int_en = 1'b0;
   logic input_buffer_full, output_buffer_full, input_overflow, intf, int_req;
   logic [1:0] phase;
   hpp_byte_t pins_in, pins_out, wdata = 8'h00, rdata, got;
   int err_total = 0, compares = 0, cycles = 0;
   always #20 i_ref_clk = ~i_ref_clk;
   hpp_host_model i_host (.i_clk(i_ref_clk), .i_data(pins_out), .o_cs_n(cs_n),
      .o_rd_n(rd_n), .o_wr_n(wr_n), .o_data(pins_in));
   hpp_slave_port i_dut (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n),
      .i_slave_port_enable(i_slave_port_enable), .i_read_strobe_n_pin(rd_n),
      .i_write_strobe_n_pin(wr_n), .i_chip_select_n_pin(cs_n),
      .i_slave_data_port(pins_in), .o_slave_data_port(pins_out),
      .o_slave_data_port_oe(oe), .i_fw_write(fw_write), .i_fw_wdata(wdata),
      .i_fw_read(fw_read), .o_fw_rdata(rdata), .i_fw_clear_overflow(clr_ov),
      .i_fw_clear_int_flag(clr_int), .i_slave_port_int_enable(int_en),
      .o_input_buffer_full(input_buffer_full), .o_output_buffer_full(output_buffer_full),
      .o_input_overflow(input_overflow), .o_slave_port_int_flag(intf),
      .o_int_request(int_req), .o_phase(phase));
   // one verdict for both the normal end and a hang
   task automatic results();
      $display("compares=%0d err_total=%0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // the whole run needs well under a thousand cycles
   always @(posedge i_ref_clk) begin
      cycles++;
      if (cycles == 5000) begin
         err_total++;
         results();
      end
   end
   // firmware pulse: one cycle wide, launched just after an edge
   task automatic pulse(ref logic s);
      @(posedge i_ref_clk);
      #1 s = 1'b1;
      @(posedge i_ref_clk);
      #1 s = 1'b0;
   endtask
   task automatic fw_wr(input hpp_byte_t d);
      wdata = d;
      pulse(fw_write);
   endtask
   // release plus sync plus phase alignment is at most ten cycles
   task automatic settle();
      repeat (12) @(posedge i_ref_clk);
      #1;
   endtask
   initial begin
      repeat (16) @(posedge i_ref_clk);
      #1 i_reset_n = 1'b1;
      `CHK({input_buffer_full, output_buffer_full, input_overflow, intf}, 4'h0)
      // phase counter walks one to four
      for (int k = 0; k < 4; k++) begin
         @(posedge i_ref_clk);
         #1 `CHK(phase, 2'(k + 1))
      end
      got = phase;
      @(posedge i_ref_clk);
      #1 `CHK(phase, 2'(got + 2'h1))
      // slave mode on: strobe pins become read, write and select strobes
      i_slave_port_enable = 1'b1;
      fw_wr(8'ha5);
      #1 `CHK(output_buffer_full, 1'b1)
      fork
         i_host.read_byte(got, 6);
         begin
            repeat (5) @(posedge i_ref_clk);
            #1 `CHK(oe, 1'b1)
            `CHK(output_buffer_full, 1'b0)
         end
      join
      `CHK(got, 8'ha5)
      `CHK(intf, 1'b0)
      settle();
      `CHK(intf, 1'b1)
      `CHK(oe, 1'b0)
      `CHK(output_buffer_full, 1'b0)
      `CHK(int_req, 1'b0)
      int_en = 1'b1;
      #1 `CHK(int_req, 1'b1)
      settle();
      `CHK(intf, 1'b1)
      pulse(clr_int);
      #1 `CHK(intf, 1'b0)
      // first byte, slow host
      i_host.write_byte(8'h3c, 7);
      settle();
      `CHK({input_buffer_full, intf, input_overflow}, 3'b110)
      `CHK(rdata, 8'h3c)
      fw_wr(8'h77); // output latch write must not touch the input side
      settle();
      `CHK(input_buffer_full, 1'b1)
      // second byte before firmware read, prompt host
      i_host.write_byte(8'h5a, 2);
      settle();
      `CHK(input_overflow, 1'b1)
      `CHK(rdata, 8'h5a)
      pulse(fw_read);
      #1 `CHK(input_buffer_full, 1'b0)
      `CHK(output_buffer_full, 1'b1)
      // leaving slave mode clears full flags but keeps overflow
      @(posedge i_ref_clk);
      #1 i_slave_port_enable = 1'b0;
      settle();
      `CHK({input_buffer_full, output_buffer_full, input_overflow}, 3'b001)
      i_host.write_byte(8'hc3, 3);
      settle();
      `CHK(input_buffer_full, 1'b0)
      `CHK(rdata, 8'h5a)
      `CHK(oe, 1'b0)
      fw_wr(8'h12);
      #1 `CHK(output_buffer_full, 1'b0)
      pulse(clr_ov);
      #1 `CHK(input_overflow, 1'b0)
      results();
   end
endmodule
